// [hw/ppdir_defs.svh]
// Constants of the parallel port mode and indirect register block.
// Assumes inclusion by bare name from the package and the bench.
`ifndef PPDIR_DEFS_SVH
`define PPDIR_DEFS_SVH

// Host byte offsets from the board base address.
`define PPDIR_WIN_OFS        6'h18
`define PPDIR_MISC_OFS       6'h1c

// Indirect register indices.
`define PPDIR_IDX_PRI_ADDR   2'h0
`define PPDIR_IDX_PRI_CNT    2'h1
`define PPDIR_IDX_SEC_ADDR   2'h2
`define PPDIR_IDX_SEC_CNT    2'h3

// Miscellaneous register field positions.
`define PPDIR_MISC_MODE_MSB  3
`define PPDIR_MISC_MODE_LSB  0
`define PPDIR_MISC_SEC_MSB   14
`define PPDIR_MISC_PRI_MSB   15

// Reset values.
`define PPDIR_REG_RST        16'h0000
`define PPDIR_MODE_RST       4'h0

// Operating mode codes.
`define PPDIR_MODE_COMPAT    4'h0
`define PPDIR_MODE_FIFO_TX_A 4'h5
`define PPDIR_MODE_FIFO_TX_B 4'h4
`define PPDIR_MODE_FIFO_RX_A 4'h7
`define PPDIR_MODE_FIFO_RX_B 4'h6
`define PPDIR_MODE_DMA_TX_A  4'h9
`define PPDIR_MODE_DMA_TX_B  4'h8
`define PPDIR_MODE_DMA_RX_A  4'hb
`define PPDIR_MODE_DMA_RX_B  4'ha

`endif

// [hw/ppdir_pkg.sv]
// Types and the mode decoder of the parallel port indirect register block.
// Assumes ppdir_defs.svh is on the include path.
`include "ppdir_defs.svh"

package ppdir_pkg;

  // Host register access, one word per cycle.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } ppdir_hreq_s;

  // Decoded operating mode.
  typedef struct packed {
    logic valid;
    logic active;
    logic fifo;
    logic dma;
    logic rx;
    logic line_a;
  } ppdir_mode_s;

  typedef enum logic [1:0] {
    PPDIR_IDLE = 2'b01,
    PPDIR_BUSY = 2'b10
  } ppdir_state_e;

  function automatic ppdir_mode_s decode_mode(input logic [3:0] m);
    ppdir_mode_s r;
    r = '0;
    case (m)
      `PPDIR_MODE_COMPAT:    r = 6'h20;
      `PPDIR_MODE_FIFO_TX_A: r = 6'h39;
      `PPDIR_MODE_FIFO_TX_B: r = 6'h38;
      `PPDIR_MODE_FIFO_RX_A: r = 6'h3b;
      `PPDIR_MODE_FIFO_RX_B: r = 6'h3a;
      `PPDIR_MODE_DMA_TX_A:  r = 6'h35;
      `PPDIR_MODE_DMA_TX_B:  r = 6'h34;
      `PPDIR_MODE_DMA_RX_A:  r = 6'h37;
      `PPDIR_MODE_DMA_RX_B:  r = 6'h36;
      default:               r = 6'h00;
    endcase
    return r;
  endfunction : decode_mode

endpackage : ppdir_pkg

// [hw/ppdir_req_sync.sv]
// Two-stage synchroniser with rising edge detection for pin inputs.
// Assumes one clock; the enable freezes all stages.
`timescale 1ns/1ps

module ppdir_req_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  // Pins
  input  wire logic [2:0] pin_in,
  // Synchronised view
  output logic      [2:0] level,
  output logic      [2:0] rise
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      prev_q <= 3'h0;
    end
    else if (en)
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;

endmodule : ppdir_req_sync

// [hw/ppdir_top.sv]
// Parallel port operating mode and indirect DMA/FIFO register set.
// Assumes host accesses arrive on CLOCK; request and INIT pins are async.
`timescale 1ns/1ps

module ppdir_top (
  // Clock, reset and enable
  input  wire logic                   CLOCK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CLK_EN,
  // Host register access
  input  wire ppdir_pkg::ppdir_hreq_s HOST_REQ,
  input  wire logic [1:0]             CSR_INDEX,
  input  wire logic                   MASTER_RST,
  input  wire logic                   BUS_INIT,
  output logic [15:0]                 HOST_RDATA,
  // User device request pins
  input  wire logic                   USER_REQ_A,
  input  wire logic                   USER_REQ_B,
  // Transfer engine side
  input  wire logic [5:0]             FIFO_LEVEL,
  input  wire logic                   XFER_ACK,
  input  wire logic                   BUF_SEL,
  input  wire logic                   PRI_DONE_EV,
  input  wire logic                   SEC_DONE_EV,
  output logic                        XFER_REQ,
  output ppdir_pkg::ppdir_mode_s      MODE_INFO,
  output logic [3:0]                  PORT_MODE,
  output logic [17:0]                 DMA_ADDR,
  output logic                        PRI_DONE,
  output logic                        SEC_DONE
);

  // --------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------

  logic [2:0] pin_level;
  logic [2:0] pin_rise;

  ppdir_req_sync u_sync (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .en     (CLK_EN),
    .pin_in ({BUS_INIT, USER_REQ_B, USER_REQ_A}),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------

  logic [15:0]            regs_q [4];
  logic [15:0]            misc_q;
  logic [15:0]            misc_d;
  logic [15:0]            rdata_q;
  logic [15:0]            rdata_d;
  logic                   pri_done_q;
  logic                   pri_done_d;
  logic                   sec_done_q;
  logic                   sec_done_d;
  logic [17:0]            dma_addr_q;
  logic [17:0]            dma_addr_d;
  ppdir_pkg::ppdir_mode_s mode_q;
  ppdir_pkg::ppdir_state_e state_q;
  ppdir_pkg::ppdir_state_e state_d;

  // --------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------

  wire clr       = MASTER_RST | pin_level[2];
  wire wr_ok     = CLK_EN & HOST_REQ.wr & ~clr;
  wire win_hit   = HOST_REQ.addr == `PPDIR_WIN_OFS;
  wire misc_hit  = HOST_REQ.addr == `PPDIR_MISC_OFS;
  wire win_wr    = wr_ok & win_hit;
  wire misc_wr   = wr_ok & misc_hit;
  wire win_rd    = CLK_EN & HOST_REQ.rd & win_hit;
  wire cnt1_wr   = win_wr & (CSR_INDEX == `PPDIR_IDX_PRI_CNT);
  wire cnt3_wr   = win_wr & (CSR_INDEX == `PPDIR_IDX_SEC_CNT);

  wire [3:0] cur_mode =
    misc_q[`PPDIR_MISC_MODE_MSB:`PPDIR_MISC_MODE_LSB];
  ppdir_pkg::ppdir_mode_s cur_info;
  assign cur_info = ppdir_pkg::decode_mode(cur_mode);

  // in FIFO modes register 1 reads back the occupancy.
  wire fifo_view = cur_info.fifo &
                   (CSR_INDEX == `PPDIR_IDX_PRI_CNT);
  wire [15:0] win_value = fifo_view ? {10'h000, FIFO_LEVEL}
                                    : regs_q[CSR_INDEX];

  // Selected request line, only while a transfer mode is valid.
  wire req_edge = cur_info.line_a ? pin_rise[0] : pin_rise[1];
  wire can_xfer = cur_info.valid & cur_info.active;
  wire start    = can_xfer & req_edge & ~clr;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------

  assign misc_d = clr     ? {12'h000, `PPDIR_MODE_RST} :
                  misc_wr ? HOST_REQ.wdata : misc_q;

  assign rdata_d = win_rd ? win_value : 16'h0000;

  // a done event in the clearing cycle leaves the flag clear.
  assign pri_done_d = clr         ? 1'b0 :
                      PRI_DONE_EV ? 1'b1 :
                      cnt1_wr     ? 1'b0 : pri_done_q;
  assign sec_done_d = clr         ? 1'b0 :
                      SEC_DONE_EV ? 1'b1 :
                      cnt3_wr     ? 1'b0 : sec_done_q;

  assign dma_addr_d = BUF_SEL ?
    {misc_q[`PPDIR_MISC_SEC_MSB], regs_q[`PPDIR_IDX_SEC_ADDR], 1'b0} :
    {misc_q[`PPDIR_MISC_PRI_MSB], regs_q[`PPDIR_IDX_PRI_ADDR], 1'b0};

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ppdir_pkg::PPDIR_IDLE:
      begin
        if (start)
          state_d = ppdir_pkg::PPDIR_BUSY;
      end
      ppdir_pkg::PPDIR_BUSY:
      begin
        if (clr || XFER_ACK || !can_xfer)
          state_d = ppdir_pkg::PPDIR_IDLE;
      end
      default:
        state_d = ppdir_pkg::PPDIR_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // Indirect registers
  // --------------------------------------------------------------

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < 4; i++)
        regs_q[i] <= `PPDIR_REG_RST;
    end
    else if (CLK_EN)
    begin
      if (clr)
      begin
        for (int i = 0; i < 4; i++)
          regs_q[i] <= `PPDIR_REG_RST;
      end
      else if (win_wr)
        regs_q[CSR_INDEX] <= HOST_REQ.wdata;
    end
  end

  // --------------------------------------------------------------
  // Control state
  // --------------------------------------------------------------

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      misc_q     <= {12'h000, `PPDIR_MODE_RST};
      rdata_q    <= 16'h0000;
      pri_done_q <= 1'b0;
      sec_done_q <= 1'b0;
      dma_addr_q <= 18'h00000;
      mode_q     <= 6'h20;
      state_q    <= ppdir_pkg::PPDIR_IDLE;
    end
    else if (CLK_EN)
    begin
      misc_q     <= misc_d;
      rdata_q    <= rdata_d;
      pri_done_q <= pri_done_d;
      sec_done_q <= sec_done_d;
      dma_addr_q <= dma_addr_d;
      mode_q     <= ppdir_pkg::decode_mode(
                      misc_d[`PPDIR_MISC_MODE_MSB:`PPDIR_MISC_MODE_LSB]);
      state_q    <= state_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------

  assign HOST_RDATA = rdata_q;
  assign XFER_REQ   = state_q[1];
  assign MODE_INFO  = mode_q;
  assign PORT_MODE  = cur_mode;
  assign DMA_ADDR   = dma_addr_q;
  assign PRI_DONE   = pri_done_q;
  assign SEC_DONE   = sec_done_q;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence seq_win_write;
    win_wr;
  endsequence

  sequence seq_req_start;
    state_q == ppdir_pkg::PPDIR_IDLE && CLK_EN && start;
  endsequence

  chk_reset_clear: assert property (
    CLK_EN && clr |=> PORT_MODE == 4'h0 && regs_q[0] == 16'h0000 &&
      regs_q[1] == 16'h0000 && regs_q[2] == 16'h0000 &&
      regs_q[3] == 16'h0000)
    else $error("reset or init did not clear mode and registers");

  chk_fifo_tx: assert property (
    misc_wr && HOST_REQ.wdata[3:2] == 2'b01 && !HOST_REQ.wdata[1]
    |=> MODE_INFO.fifo && !MODE_INFO.rx &&
        MODE_INFO.line_a == $past(HOST_REQ.wdata[0]))
    else $error("fifo transmit mode decoded wrongly");

  chk_fifo_rx: assert property (
    misc_wr && HOST_REQ.wdata[3:0] == 4'h7
    |=> MODE_INFO.fifo && MODE_INFO.rx && MODE_INFO.line_a)
    else $error("fifo receive mode decoded wrongly");

  chk_dma_tx: assert property (
    misc_wr && HOST_REQ.wdata[3:0] == 4'h8
    |=> MODE_INFO.dma && !MODE_INFO.rx && !MODE_INFO.line_a)
    else $error("dma transmit mode decoded wrongly");

  chk_dma_rx: assert property (
    misc_wr && HOST_REQ.wdata[3:0] == 4'hb
    |=> MODE_INFO.dma && MODE_INFO.rx && !MODE_INFO.fifo)
    else $error("dma receive mode decoded wrongly");

  chk_window_store: assert property (
    seq_win_write ##1 (CLK_EN && HOST_REQ.rd && win_hit && !clr &&
      !fifo_view && CSR_INDEX == $past(CSR_INDEX))
    |=> HOST_RDATA == $past(HOST_REQ.wdata, 2))
    else $error("window read did not return last write");

  chk_pri_addr: assert property (
    CLK_EN && !BUF_SEL |=> DMA_ADDR ==
      {$past(misc_q[15]), $past(regs_q[0]), 1'b0})
    else $error("primary dma address wrong");

  chk_sec_addr: assert property (
    CLK_EN && BUF_SEL |=> DMA_ADDR[17:1] ==
      {$past(misc_q[14]), $past(regs_q[2])} && !DMA_ADDR[0])
    else $error("secondary dma address wrong");

  chk_done_clear: assert property (
    cnt1_wr && !PRI_DONE_EV |=> !PRI_DONE)
    else $error("count write did not clear primary done");

  chk_fifo_count: assert property (
    win_rd && fifo_view |=> HOST_RDATA == {10'h000, $past(FIFO_LEVEL)})
    else $error("fifo occupancy not reported");

  chk_reserved_idle: assert property (
    CLK_EN && !cur_info.valid |=> !XFER_REQ)
    else $error("transfer requested in reserved mode");

  chk_req_start: assert property (
    seq_req_start |=> XFER_REQ)
    else $error("request edge did not start a transfer");

  chk_clear_flags: assert property (
    CLK_EN && clr |=> !PRI_DONE && !SEC_DONE && !XFER_REQ)
    else $error("reset or init left a flag or request set");

endmodule : ppdir_top

// [bench/ppdir_user_dev.sv]
// User device model: pulses a request pin and acks pending transfers.
// Assumes the bench commands each pulse and sets the acknowledge delay.
`timescale 1ns/1ps

module ppdir_user_dev (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Commands, bit 0 line A, bit 1 line B
  input  wire logic [1:0] fire,
  input  wire logic [3:0] ack_wait,
  input  wire logic       xfer_req,
  // Pins
  output logic            req_a,
  output logic            req_b,
  output logic            xfer_ack
);
  logic [3:0] hold_q;
  logic [3:0] wait_q;

  // A request pin stays high for a few cycles, then falls back low.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_a    <= 1'b0;
      req_b    <= 1'b0;
      hold_q   <= 4'h0;
      wait_q   <= 4'h0;
      xfer_ack <= 1'b0;
    end
    else
    begin
      xfer_ack <= 1'b0;
      if (fire != 2'b00)
      begin
        req_a  <= fire[0];
        req_b  <= fire[1];
        hold_q <= 4'h4;
      end
      else if (hold_q != 4'h0)
        hold_q <= hold_q - 4'h1;
      else
      begin
        req_a <= 1'b0;
        req_b <= 1'b0;
      end
      if (xfer_req && !xfer_ack)
      begin
        if (wait_q == ack_wait)
        begin
          xfer_ack <= 1'b1;
          wait_q   <= 4'h0;
        end
        else
          wait_q <= wait_q + 4'h1;
      end
      else
        wait_q <= 4'h0;
    end
  end
endmodule : ppdir_user_dev

// [bench/parallel_port_dma_indirect_regs_bench.sv]
// Self-checking bench of the mode and indirect register block.
// Assumes ppdir_defs.svh is on the include path.
`timescale 1ns/1ps
`include "ppdir_defs.svh"

module parallel_port_dma_indirect_regs_bench;
  logic                   clk, rst, mres, binit, pri_ev, sec_ev, bsel, en;
  ppdir_pkg::ppdir_hreq_s hreq;
  ppdir_pkg::ppdir_mode_s info;
  logic [1:0]             idx, fire;
  logic [3:0]             ack_wait, pmode;
  logic [5:0]             lvl;
  logic [15:0]            rdata;
  logic [17:0]            dma_addr;
  logic                   ua, ub, xack, xreq, pdone, sdone;
  logic [15:0]            pat [4] = '{16'h1234, 16'h0055, 16'habcd, 16'h00aa};
  logic [3:0]             codes [11] = '{4'h0, 4'h5, 4'h4, 4'h7, 4'h6,
                                        4'h9, 4'h8, 4'hb, 4'ha, 4'h3, 4'hf};
  logic [5:0]             infos [11] = '{6'h20, 6'h39, 6'h38, 6'h3b, 6'h3a,
                                        6'h35, 6'h34, 6'h37, 6'h36, 6'h00,
                                        6'h00};
  int                     n_errors = 0;
  int                     n_tests = 0;
  int                     cycles = 0;
  logic [1:0]             good;

  ppdir_top DUT (.CLOCK(clk), .SYS_RST(rst), .CLK_EN(en), .HOST_REQ(hreq),
    .CSR_INDEX(idx), .MASTER_RST(mres), .BUS_INIT(binit),
    .HOST_RDATA(rdata), .USER_REQ_A(ua), .USER_REQ_B(ub), .FIFO_LEVEL(lvl),
    .XFER_ACK(xack), .BUF_SEL(bsel), .PRI_DONE_EV(pri_ev),
    .SEC_DONE_EV(sec_ev), .XFER_REQ(xreq), .MODE_INFO(info),
    .PORT_MODE(pmode), .DMA_ADDR(dma_addr), .PRI_DONE(pdone),
    .SEC_DONE(sdone));

  ppdir_user_dev partner (.clk(clk), .rst(rst), .fire(fire),
    .ack_wait(ack_wait), .xfer_req(xreq), .req_a(ua), .req_b(ub),
    .xfer_ack(xack));

  always #50 clk = ~clk;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [17:0] exp,
                       input logic [17:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wr(input logic [5:0] a, input logic [1:0] ix,
                    input logic [15:0] d);
    @(posedge clk);
    hreq <= '{1'b1, 1'b0, a, d};
    idx  <= ix;
    @(posedge clk);
    hreq <= '0;
  endtask : wr

  task automatic rdck(input logic [5:0] a, input logic [1:0] ix,
                      input logic [15:0] exp);
    @(posedge clk);
    hreq <= '{1'b0, 1'b1, a, 16'h0000};
    idx  <= ix;
    @(posedge clk);
    hreq <= '0;
    #1;
    check("read data", {2'b00, exp}, {2'b00, rdata});
  endtask : rdck

  // Writes a window word and reads it back in the very next cycle.
  task automatic wrrd(input logic [1:0] ix, input logic [15:0] d);
    @(posedge clk);
    hreq <= '{1'b1, 1'b0, `PPDIR_WIN_OFS, d};
    idx  <= ix;
    @(posedge clk);
    hreq <= '{1'b0, 1'b1, `PPDIR_WIN_OFS, 16'h0000};
    @(posedge clk);
    hreq <= '0;
    #1;
    check("read back", {2'b00, d}, {2'b00, rdata});
  endtask : wrrd

  task automatic reset_master;
    @(posedge clk);
    mres <= 1'b1;
    @(posedge clk);
    mres <= 1'b0;
  endtask : reset_master

  // Pulses request lines and reports whether a transfer was raised.
  task automatic try_line(input logic [1:0] f, input logic exp,
                          input logic [3:0] w);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    fire     <= f;
    ack_wait <= w;
    @(posedge clk);
    fire <= 2'b00;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      if (xreq === 1'b1)
        seen = 1'b1;
    end
    check("transfer raised", {17'h0, exp}, {17'h0, seen});
    check("transfer ended", 18'h0, {17'h0, xreq});
  endtask : try_line

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    {clk, mres, binit, pri_ev, sec_ev, bsel, idx, fire} = '0;
    hreq = '0;
    en = 1'b1;
    ack_wait = 4'h0;
    lvl = 6'h20;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    check("mode", 18'h0, {14'h0, pmode});
    check("info", 18'h20, {12'h0, info});
    for (int i = 0; i < 4; i++)
      rdck(`PPDIR_WIN_OFS, i[1:0], 16'h0000);
    reset_master();
    wr(`PPDIR_MISC_OFS, 2'h0, 16'h8009);
    for (int i = 0; i < 4; i++)
      wr(`PPDIR_WIN_OFS, i[1:0], pat[i]);
    for (int i = 0; i < 4; i++)
      rdck(`PPDIR_WIN_OFS, i[1:0], pat[i]);
    wrrd(2'h3, pat[3]);
    @(posedge clk);
    en <= 1'b0;
    wr(`PPDIR_WIN_OFS, 2'h0, 16'hdead);
    @(posedge clk);
    en <= 1'b1;
    rdck(`PPDIR_WIN_OFS, 2'h0, pat[0]);
    idle(2);
    check("pri addr", {1'b1, pat[0], 1'b0}, dma_addr);
    @(posedge clk);
    bsel <= 1'b1;
    idle(2);
    check("sec addr", {1'b0, pat[2], 1'b0}, dma_addr);
    wr(6'h10, 2'h0, 16'hffff);
    rdck(`PPDIR_WIN_OFS, 2'h0, pat[0]);
    rdck(`PPDIR_MISC_OFS, 2'h0, 16'h0000);
    @(posedge clk);
    {pri_ev, sec_ev} <= 2'b11;
    @(posedge clk);
    {pri_ev, sec_ev} <= 2'b00;
    idle(1);
    check("done flags", 18'h3, {16'h0, sdone, pdone});
    wr(`PPDIR_WIN_OFS, 2'h1, 16'h0010);
    idle(1);
    check("done flags", 18'h2, {16'h0, sdone, pdone});
    wr(`PPDIR_WIN_OFS, 2'h3, 16'h0010);
    idle(1);
    check("done flags", 18'h0, {16'h0, sdone, pdone});
    reset_master();
    idle(1);
    check("mode", 18'h0, {14'h0, pmode});
    for (int i = 0; i < 4; i++)
      rdck(`PPDIR_WIN_OFS, i[1:0], 16'h0000);
    wr(`PPDIR_MISC_OFS, 2'h0, {12'h000, `PPDIR_MODE_FIFO_TX_A});
    wr(`PPDIR_WIN_OFS, 2'h1, 16'h0007);
    rdck(`PPDIR_WIN_OFS, 2'h1, 16'h0020);
    wr(`PPDIR_WIN_OFS, 2'h0, 16'h5555);
    binit <= 1'b1;
    repeat (4) @(posedge clk);
    binit <= 1'b0;
    idle(2);
    rdck(`PPDIR_WIN_OFS, 2'h0, 16'h0000);
    check("mode", 18'h0, {14'h0, pmode});
    for (int i = 0; i < 11; i++)
    begin
      reset_master();
      wr(`PPDIR_MISC_OFS, 2'h0, {12'h000, codes[i]});
      idle(1);
      check("mode", {14'h0, codes[i]}, {14'h0, pmode});
      check("info", {12'h0, infos[i]}, {12'h0, info});
      good = infos[i][0] ? 2'b01 : 2'b10;
      if (infos[i][4])
      begin
        try_line(~good, 1'b0, 4'h0);
        try_line(good, 1'b1, i[0] ? 4'h6 : 4'h0);
      end
      else
        try_line(2'b11, 1'b0, 4'h0);
    end
    report_and_stop();
  end
endmodule : parallel_port_dma_indirect_regs_bench
